// File: hw/dual_clock_fifo_prog_flags.sv
// Top of the nine-bit FIFO with full, empty and programmable flags.
// Assumes write and read clock edges arrive as one-cycle ticks on clk,
// and all pins are synchronous to clk.

module dual_clock_fifo_prog_flags
  import fifo_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic master_reset_n,
  input wire push_port_t push,
  input wire pop_port_t pop,
  output logic [DATA_W-1:0] read_bus,
  output logic full_flag_n,
  output logic almost_full_n,
  output logic empty_flag_n,
  output logic almost_empty_n
);

  // ----------------------------------------------------------------
  // Sizes and state
  // ----------------------------------------------------------------
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_W = PW'(DEPTH);
  localparam logic [PW-1:0] PTR_FIRST = '0;

  typedef struct packed {
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [DATA_W-1:0] read_word;
    logic full_n;
    logic almost_full_n;
    logic empty_n;
    logic almost_empty_n;
    logic load_mode;
  } fifo_state_t;

  // Flag levels forced by a master reset
  localparam fifo_state_t STATE_RESET = '{wptr: PTR_FIRST,
    rptr: PTR_FIRST, read_word: '0, full_n: 1'b1, almost_full_n: 1'b1,
    empty_n: 1'b0, almost_empty_n: 1'b0, load_mode: 1'b0};

  fifo_state_t state_reg;
  fifo_state_t state_next;

  logic [1:0] rst_sync_reg;
  logic rst_n_sync;
  logic push_take;
  logic pop_take;
  logic load_write;
  logic load_read;
  logic [DATA_W-1:0] store_word;
  offset_set_t offsets;
  logic [OFFSET_W-1:0] offset_word;
  logic [PW-1:0] empty_level;
  logic [PW-1:0] full_level;
  logic [PW-1:0] fill_now;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // High register sits above the low one, cut to the address width
  function automatic logic [PW-1:0] threshold(
    input logic [OFFSET_W-1:0] high,
    input logic [OFFSET_W-1:0] low
  );
    threshold = PW'({high[AW-OFFSET_W-1:0], low});
  endfunction

  // Unread words; the extra pointer bit tells full from empty
  function automatic logic [PW-1:0] fill(
    input logic [PW-1:0] wp,
    input logic [PW-1:0] rp
  );
    fill = wp - rp;
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Async assert, release after two clocks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n_sync = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // Accept decisions
  // ----------------------------------------------------------------
  // Writes: pin high is both the second enable and the load idle level
  assign push_take = master_reset_n && push.tick &&
    !push.push_enable_a_n && push.push_enable_b_or_load_n &&
    state_reg.full_n;

  // Offset loads only exist in load mode
  assign load_write = master_reset_n && push.tick && state_reg.load_mode &&
    !push.push_enable_b_or_load_n && !push.push_enable_a_n;

  // Reads: in load mode a low pin diverts the read to the offsets
  assign pop_take = master_reset_n && pop.tick &&
    !pop.pop_enable_a_n && !pop.pop_enable_b_n &&
    state_reg.empty_n &&
    (!state_reg.load_mode || push.push_enable_b_or_load_n);

  assign load_read = master_reset_n && pop.tick && state_reg.load_mode &&
    !push.push_enable_b_or_load_n &&
    !pop.pop_enable_a_n && !pop.pop_enable_b_n;

  assign empty_level = threshold(offsets[SEL_EMPTY_HIGH],
    offsets[SEL_EMPTY_LOW]);
  assign full_level = threshold(offsets[SEL_FULL_HIGH],
    offsets[SEL_FULL_LOW]);
  assign fill_now = fill(state_reg.wptr, state_reg.rptr);

  // ----------------------------------------------------------------
  // Storage and offsets
  // ----------------------------------------------------------------
  fifo_store #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) store_inst (
    .clk(clk),
    .wr_en(push_take),
    .wr_addr(state_reg.wptr[AW-1:0]),
    .wr_data(push.write_bus),
    .rd_addr(state_reg.rptr[AW-1:0]),
    .rd_data(store_word)
  );

  offset_bank offset_inst (
    .clk(clk),
    .rst_n(rst_n_sync),
    .clear(!master_reset_n),
    .wr_en(load_write),
    .wr_data(push.write_bus[OFFSET_W-1:0]),
    .rd_en(load_read),
    .offsets(offsets),
    .rd_word(offset_word)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Each side looks only at its own tick, so either may run alone
  always_comb begin
    logic [PW-1:0] wptr_n;
    logic [PW-1:0] rptr_n;
    logic [PW-1:0] wfill;
    logic [PW-1:0] rfill;
    wptr_n = state_reg.wptr + PW'(push_take);
    rptr_n = state_reg.rptr + PW'(pop_take);
    wfill = fill(wptr_n, state_reg.rptr);
    rfill = fill(state_reg.wptr, rptr_n);
    state_next = state_reg;
    state_next.wptr = wptr_n;
    state_next.rptr = rptr_n;
    // Write side flags: the old read pointer errs towards full, never over
    if (push.tick) begin
      state_next.full_n = (wfill != DEPTH_W);
      state_next.almost_full_n =
        (wfill < (DEPTH_W - full_level));
    end
    // Read side flags: the old write pointer errs towards empty
    if (pop.tick) begin
      state_next.empty_n = (rfill != PTR_FIRST);
      state_next.almost_empty_n =
        (rfill > empty_level);
    end
    // Output register moves only on an accepted read of either kind or a reset
    if (pop_take) begin
      state_next.read_word = store_word;
    end else if (load_read) begin
      state_next.read_word = DATA_W'(offset_word);
    end
    // Held reset: the pin level on the last low cycle sets the mode
    if (!master_reset_n) begin
      state_next = STATE_RESET;
      state_next.load_mode = !push.push_enable_b_or_load_n;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state flops
  assign read_bus = state_reg.read_word;
  assign full_flag_n = state_reg.full_n;
  assign almost_full_n = state_reg.almost_full_n;
  assign empty_flag_n = state_reg.empty_n;
  assign almost_empty_n = state_reg.almost_empty_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_sync);

  sequence s_reset_held;
    !master_reset_n;
  endsequence

  sequence s_write_try;
    master_reset_n && push.tick && !push.push_enable_a_n &&
      push.push_enable_b_or_load_n;
  endsequence

  sequence s_write_only;
    master_reset_n && push.tick && !pop.tick;
  endsequence

  sequence s_read_only;
    master_reset_n && pop.tick && !push.tick;
  endsequence

  // A read the device takes: enables low, not empty, pin high in load mode
  sequence s_read_take;
    master_reset_n && pop.tick && !pop.pop_enable_a_n &&
      !pop.pop_enable_b_n && empty_flag_n &&
      (!state_reg.load_mode || push.push_enable_b_or_load_n);
  endsequence

  a_reset_clears_all:
    assert property (s_reset_held |=> state_reg.wptr == PTR_FIRST &&
      state_reg.rptr == PTR_FIRST && read_bus == '0 && full_flag_n &&
      almost_full_n && !empty_flag_n && !almost_empty_n)
    else $error("master reset left pointers, flags or output set");

  a_mode_capture:
    assert property (s_reset_held ##1 master_reset_n |->
      state_reg.load_mode == !$past(push.push_enable_b_or_load_n))
    else $error("mode not taken from load pin at reset release");

  a_write_advance:
    assert property (s_write_try and full_flag_n |=>
      state_reg.wptr == $past(state_reg.wptr) + PW'(1))
    else $error("accepted write did not advance write pointer");

  a_full_blocks:
    assert property (s_write_try and !full_flag_n |=>
      $stable(state_reg.wptr))
    else $error("write pointer moved while full");

  a_full_level:
    assert property (s_write_only |=>
      full_flag_n == (fill_now != DEPTH_W))
    else $error("full flag disagrees with stored word count");

  a_write_flags_hold:
    assert property (master_reset_n && !push.tick ##1 master_reset_n |->
      $stable(full_flag_n) && $stable(almost_full_n))
    else $error("write side flag moved without a write tick");

  a_read_flags_hold:
    assert property (master_reset_n && !pop.tick ##1 master_reset_n |->
      $stable(empty_flag_n) && $stable(almost_empty_n))
    else $error("read side flag moved without a read tick");

  a_empty_refuse:
    assert property (master_reset_n && pop.tick && !empty_flag_n |=>
      $stable(state_reg.rptr))
    else $error("read pointer moved while empty");

  a_output_hold:
    assert property (master_reset_n &&
      (pop.pop_enable_a_n || pop.pop_enable_b_n) |=> $stable(read_bus))
    else $error("output changed with a read enable high");

  a_almost_empty_level:
    assert property (s_read_only |=>
      almost_empty_n == (fill_now > empty_level))
    else $error("almost-empty flag disagrees with threshold");

  a_almost_full_level:
    assert property (s_write_only |=>
      almost_full_n == (fill_now < (DEPTH_W - $past(full_level))))
    else $error("almost-full flag disagrees with threshold");

  a_empty_rises:
    assert property ((s_write_try and full_flag_n) ##1
      (s_read_only and !empty_flag_n) |=> empty_flag_n)
    else $error("empty flag not raised on first read tick after write");

  // The write side sees the freed slot at its very next tick
  a_full_rises:
    assert property ((s_read_take and (!full_flag_n && !push.tick)) ##1
      (master_reset_n && push.tick && !pop.tick) |=> full_flag_n)
    else $error("full flag not raised on first write tick after read");

endmodule

// File: hw/fifo_pkg.sv
// Shared constants and carrier types for the programmable-flag FIFO.
// Assumes one system clock; write and read clock edges arrive as
// one-cycle tick pulses synchronous to that clock.

package fifo_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 9;
  localparam int DEPTH_DEFAULT = 512;
  localparam int OFFSET_W = 8;
  localparam int OFFSET_COUNT = 4;
  localparam int SEL_W = 2;

  // ----------------------------------------------------------------
  // Offset register order and defaults
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_EMPTY_LOW = 2'h0;
  localparam logic [SEL_W-1:0] SEL_EMPTY_HIGH = 2'h1;
  localparam logic [SEL_W-1:0] SEL_FULL_LOW = 2'h2;
  localparam logic [SEL_W-1:0] SEL_FULL_HIGH = 2'h3;
  localparam logic [SEL_W-1:0] SEL_STEP = 2'h1;
  localparam logic [OFFSET_W-1:0] EMPTY_LOW_DEFAULT = 8'h07;
  localparam logic [OFFSET_W-1:0] EMPTY_HIGH_DEFAULT = 8'h00;
  localparam logic [OFFSET_W-1:0] FULL_LOW_DEFAULT = 8'h07;
  localparam logic [OFFSET_W-1:0] FULL_HIGH_DEFAULT = 8'h00;

  typedef logic [OFFSET_COUNT-1:0][OFFSET_W-1:0] offset_set_t;

  localparam offset_set_t OFFSET_DEFAULTS = {FULL_HIGH_DEFAULT,
    FULL_LOW_DEFAULT, EMPTY_HIGH_DEFAULT, EMPTY_LOW_DEFAULT};

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tick;
    logic push_enable_a_n;
    logic push_enable_b_or_load_n;
    logic [DATA_W-1:0] write_bus;
  } push_port_t;

  typedef struct packed {
    logic tick;
    logic pop_enable_a_n;
    logic pop_enable_b_n;
  } pop_port_t;

  typedef struct packed {
    offset_set_t regs;
    logic [SEL_W-1:0] wr_sel;
    logic [SEL_W-1:0] rd_sel;
  } offset_state_t;

endpackage

// File: hw/fifo_store.sv
// Word storage for the FIFO: one write port, one combinational read.
// Assumes the caller gates writes; contents are undefined until written.

module fifo_store
  import fifo_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEFAULT,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);

  // ----------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];

  // No reset on the array: keeps it mappable onto block RAM
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read is combinational so the top can register it once
  assign rd_data = mem[rd_addr];

endmodule

// File: hw/offset_bank.sv
// Four 8-bit threshold offset registers with write and read selectors.
// Assumes the top gates strobes with load mode and the load pin.

module offset_bank
  import fifo_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [OFFSET_W-1:0] wr_data,
  input wire logic rd_en,
  output offset_set_t offsets,
  output logic [OFFSET_W-1:0] rd_word
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  offset_state_t state_reg;
  offset_state_t state_next;

  // Next state: selected register loads, selectors step and wrap
  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < OFFSET_COUNT; i++) begin
      if (wr_en && (state_reg.wr_sel == SEL_W'(i))) begin
        state_next.regs[i] = wr_data;
      end
    end
    if (wr_en) begin
      state_next.wr_sel = state_reg.wr_sel + SEL_STEP;
    end
    if (rd_en) begin
      state_next.rd_sel = state_reg.rd_sel + SEL_STEP;
    end
    if (clear) begin
      state_next.regs = OFFSET_DEFAULTS;
      state_next.wr_sel = SEL_EMPTY_LOW;
      state_next.rd_sel = SEL_EMPTY_LOW;
    end
  end

  // Register; selectors survive load going high again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{regs: OFFSET_DEFAULTS, wr_sel: SEL_EMPTY_LOW,
        rd_sel: SEL_EMPTY_LOW};
    end else begin
      state_reg <= state_next;
    end
  end

  assign offsets = state_reg.regs;
  assign rd_word = state_reg.regs[state_reg.rd_sel];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_load_write;
    wr_en && !clear;
  endsequence

  a_load_step_wrap:
    assert property (s_load_write |=>
      state_reg.wr_sel == $past(state_reg.wr_sel) + SEL_STEP &&
      state_reg.regs[$past(state_reg.wr_sel)] == $past(wr_data))
    else $error("offset load did not store and step");

  a_select_kept:
    assert property (!wr_en && !clear |=> $stable(state_reg.wr_sel))
    else $error("offset write selector moved without a load");

endmodule

// File: tb/stream_partner.sv
// Writer and reader logic on the far side of the FIFO's two ports.
// Assumes the bench enables it only after reset and never asks for
// offset loads and offset reads in the same run.

module stream_partner
  import fifo_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic pin,
  input int wr_pct,
  input int rd_pct,
  output push_port_t push,
  output pop_port_t pop
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Idle levels at time zero
  // ----------------------------------------------------------------
  initial begin
    push = '0;
    push.push_enable_a_n = 1'b1;
    push.push_enable_b_or_load_n = 1'b1;
    pop = '0;
    pop.pop_enable_a_n = 1'b1;
    pop.pop_enable_b_n = 1'b1;
  end

  // ----------------------------------------------------------------
  // Random ticks and enables
  // ----------------------------------------------------------------
  // No tick until go, so nothing is written before reset
  // Enables drop out one time in ten to show refused transfers
  always @(posedge clk) begin
    push.tick <= go && ($urandom_range(99) < wr_pct);
    push.push_enable_a_n <= ($urandom_range(9) == 0);
    push.push_enable_b_or_load_n <= pin;
    push.write_bus <= DATA_W'($urandom);
    pop.tick <= go && ($urandom_range(99) < rd_pct);
    pop.pop_enable_a_n <= ($urandom_range(9) == 0);
    pop.pop_enable_b_n <= ($urandom_range(9) == 0);
  end

endmodule

// File: tb/testbench.sv
// Self-checking bench: a queue model of the FIFO beside the design.
// Assumes ticks on one clk stand for write and read clock edges.

module testbench;
  import fifo_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int FIFO_DEPTH = 512;
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int LIMIT = 20000;

  logic clk, reset_n, master_reset_n, go, pin;
  int wr_pct, rd_pct, cycles, miscompares, samples_checked;
  push_port_t push;
  pop_port_t pop;
  logic [DATA_W-1:0] read_bus;
  logic full_flag_n, almost_full_n, empty_flag_n, almost_empty_n;

  // Model state
  int count, n_thr, m_thr, wsel, rsel, wc, rc;
  bit w, r;
  logic [OFFSET_W-1:0] offs [4];
  logic [DATA_W-1:0] q [$];
  logic lmode, e_full_n, e_af_n, e_empty_n, e_ae_n;
  logic [DATA_W-1:0] e_data;

  dual_clock_fifo_prog_flags #(.DEPTH(FIFO_DEPTH))
    dual_clock_fifo_prog_flags_i (
    .clk(clk),
    .reset_n(reset_n),
    .master_reset_n(master_reset_n),
    .push(push),
    .pop(pop),
    .read_bus(read_bus),
    .full_flag_n(full_flag_n),
    .almost_full_n(almost_full_n),
    .empty_flag_n(empty_flag_n),
    .almost_empty_n(almost_empty_n)
  );

  stream_partner stream_partner_i (
    .clk(clk),
    .go(go),
    .pin(pin),
    .wr_pct(wr_pct),
    .rd_pct(rd_pct),
    .push(push),
    .pop(pop)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Behavioural model
  // ----------------------------------------------------------------
  task automatic model_init();
    count = 0;
    q.delete();
    offs = '{EMPTY_LOW_DEFAULT, EMPTY_HIGH_DEFAULT,
      FULL_LOW_DEFAULT, FULL_HIGH_DEFAULT};
    wsel = 0;
    rsel = 0;
    e_full_n = 1'b1;
    e_af_n = 1'b1;
    e_empty_n = 1'b0;
    e_ae_n = 1'b0;
    e_data = '0;
  endtask

  // Flags judged from old flags, so acceptance matches the device
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      model_init();
      lmode = 1'b0;
    end else if (!master_reset_n) begin
      model_init();
      lmode = !push.push_enable_b_or_load_n;
    end else begin
      n_thr = int'({offs[1][AW-9:0], offs[0]});
      m_thr = int'({offs[3][AW-9:0], offs[2]});
      w = push.tick && !push.push_enable_a_n &&
        push.push_enable_b_or_load_n && e_full_n;
      r = pop.tick && !pop.pop_enable_a_n && !pop.pop_enable_b_n &&
        e_empty_n && (!lmode || push.push_enable_b_or_load_n);
      if (lmode && push.tick && !push.push_enable_b_or_load_n &&
          !push.push_enable_a_n) begin
        offs[wsel] = push.write_bus[OFFSET_W-1:0];
        wsel = (wsel + 1) % 4;
      end
      if (lmode && pop.tick && !push.push_enable_b_or_load_n &&
          !pop.pop_enable_a_n && !pop.pop_enable_b_n) begin
        e_data = {1'b0, offs[rsel]};
        rsel = (rsel + 1) % 4;
      end
      if (w) q.push_back(push.write_bus);
      if (r) e_data = q.pop_front();
      wc = count + int'(w);
      rc = count - int'(r);
      if (push.tick) begin
        e_full_n = (wc != FIFO_DEPTH);
        e_af_n = (wc < FIFO_DEPTH - m_thr);
      end
      if (pop.tick) begin
        e_empty_n = (rc != 0);
        e_ae_n = (rc > n_thr);
      end
      count = count + int'(w) - int'(r);
    end
  end

  // ----------------------------------------------------------------
  // Comparison and verdict
  // ----------------------------------------------------------------
  task automatic check_bit(input logic got, input logic exp,
    input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic check_word(input logic [DATA_W-1:0] got,
    input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t read_bus got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Outputs settle after the edge, so look at them mid-cycle
  always @(negedge clk) begin
    check_bit(full_flag_n, e_full_n, "full");
    check_bit(almost_full_n, e_af_n, "almost full");
    check_bit(empty_flag_n, e_empty_n, "empty");
    check_bit(almost_empty_n, e_ae_n, "almost empty");
    check_word(read_bus, e_data);
  end

  // A hang is cut short here
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Scenario steps
  // ----------------------------------------------------------------
  task automatic run(input int wp, input int rp, input logic p,
    input int n);
    @(posedge clk);
    go <= 1'b1;
    wr_pct <= wp;
    rd_pct <= rp;
    pin <= p;
    repeat (n) @(posedge clk);
  endtask

  // Pin settles through the partner before the reset samples it
  task automatic mreset(input logic p);
    @(posedge clk);
    go <= 1'b0;
    pin <= p;
    repeat (2) @(posedge clk);
    master_reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    master_reset_n <= 1'b1;
  endtask

  initial begin
    void'($urandom(32'h388839f9));
    reset_n = 1'b0;
    master_reset_n = 1'b1;
    go = 1'b0;
    pin = 1'b1;
    wr_pct = 0;
    rd_pct = 0;
    cycles = 0;
    miscompares = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    mreset(1'b1);
    run(100, 0, 1'b1, 700);
    run(0, 100, 1'b1, 700);
    run(50, 50, 1'b1, 1500);
    run(50, 50, 1'b0, 100);
    mreset(1'b0);
    run(100, 0, 1'b0, 14);
    run(0, 0, 1'b1, 2);
    run(0, 100, 1'b0, 10);
    run(100, 0, 1'b0, 2);
    run(60, 40, 1'b1, 2500);
    run(100, 0, 1'b1, 600);
    run(50, 50, 1'b1, 200);
    run(0, 100, 1'b1, 800);
    give_verdict();
  end

endmodule
